// >>> logic/rxpf_top.v
// Purpose: 64-byte shared buffer with rx packet path, alerts and CRC unit
// Assumes: rx_* inputs synchronous to clock; rx_end never with rx_valid
// Notes: AHB-Lite slave, zero wait states except a data-port write
//
// Summary of operation
// - Multi-packet mode keeps receiving packets until software clears it.
// - A status byte of error flags follows each stored packet.
// - First byte of each packet is its length, stored first.
// - Buffer holds 64 bytes; write when full is dropped, sets overflow.
// - Length byte must be at least four times the minimum field.
// - Length byte below four times maximum field; zero means 256.
// - Packets outside the window are dropped; receiver stays active.
// - Two-bit select picks the CRC seed from four values.
// - CRC is 16 bits with polynomial x16+x12+x5+1.
// - CRC result reads as separate high and low byte registers.
// - Bit order control feeds bytes MSB first, else LSB first.
// - Host data-port write stores a byte and advances write pointer.
// - Host data-port read returns a byte and advances read pointer.
// - Seven-bit fill count equals write minus read pointer.
// - Flush resets pointers, zeroes count, clears overflow, drops bytes.
// - Overflow stays set until a flush.
// - Near-full is set when 64 minus count is at most threshold.
// - Near-empty is set when count is at most threshold.
// - Enabled alert rising to one asserts the interrupt pin.
// - Near-full rising edge sets the latched near-full request.
// - CRC request flag is set once the buffer has been consumed.
`timescale 1ns/1ps
`include "rxpf_regs.vh"

module rxpf_top (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Receive decoder side
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_end,
  input wire [3:0] rx_err,
  output reg rx_active,
  // Interrupt
  output reg irq
);

  // Buffer storage and pointers
  reg [7:0] mem [0:63];
  reg [6:0] wp_reg;
  reg [6:0] rp_reg;
  wire [6:0] fill = wp_reg - rp_reg;
  wire full = (fill == `RXPF_DEPTH);
  wire empty = (fill == 7'd0);

  // Software-visible state
  reg [5:0] thr_reg;
  reg ovf_reg;
  reg [3:0] err_reg;
  reg [1:0] ien_reg;
  reg [1:0] irqf_reg;
  reg crc_done_reg;
  reg [2:0] cfg_reg;
  reg multi_reg;
  reg [5:0] wlo_reg;
  reg [5:0] whi_reg;
  reg ne_reg;
  reg nf_reg;

  // Bus pipeline
  reg d_wr_reg;
  reg [7:0] d_addr_reg;
  reg hw_pend_reg;
  reg [7:0] hw_data_reg;

  // Receive packet state
  reg rx_first_reg;
  reg rx_keep_reg;

  // CRC engine
  localparam C_IDLE = 2'd0;
  localparam C_FETCH = 2'd1;
  localparam C_SHIFT = 2'd2;
  reg [1:0] c_state_reg;
  reg [15:0] crc_reg;
  reg [7:0] c_sh_reg;
  reg [2:0] c_cnt_reg;
  reg crc_rdy_reg;

  // Address phase
  wire a_sel = hsel & htrans[1] & hready;
  wire [7:0] a_addr = haddr[7:0];
  wire d_we = d_wr_reg & hready;
  wire [7:0] wd8 = hwdata[7:0];

  // Software strobes
  wire w_data = d_we & (d_addr_reg == `RXPF_A_DATA);
  wire w_fill = d_we & (d_addr_reg == `RXPF_A_FILL);
  wire w_irq = d_we & (d_addr_reg == `RXPF_A_IRQ);
  wire w_mirq = d_we & (d_addr_reg == `RXPF_A_MIRQ);
  wire w_rxcfg = d_we & (d_addr_reg == `RXPF_A_RXCFG);
  wire w_crcgo = d_we & (d_addr_reg == `RXPF_A_CRCGO)
               & wd8[`RXPF_F_CRCGO];
  wire flush = w_fill & wd8[`RXPF_F_FLUSH];

  // Length window check
  wire [8:0] len9 = {1'b0, rx_data};
  wire [8:0] lo9 = {1'b0, wlo_reg, 2'b00};
  wire [8:0] hi9 = (whi_reg == 6'h00) ? `RXPF_MAX_OPEN
                 : {1'b0, whi_reg, 2'b00};
  wire lo_ok = (len9 >= lo9);
  wire hi_ok = (len9 < hi9);
  wire in_win = lo_ok & hi_ok;

  // Receive writes: length byte, payload, then status byte
  wire rx_take = rx_active & rx_valid;
  wire rx_bwr = rx_take & (rx_first_reg ? in_win : rx_keep_reg);
  wire rx_swr = rx_active & rx_end & ~rx_first_reg & rx_keep_reg;
  wire rx_wr = rx_bwr | rx_swr;
  wire [7:0] rx_status = {4'h0, rx_err};
  wire [7:0] rx_wdata = rx_swr ? rx_status : rx_data;

  // Write arbitration, receiver first
  wire host_wr = hw_pend_reg & ~rx_wr;
  wire wr_any = rx_wr | host_wr;
  wire [7:0] wdata = rx_wr ? rx_wdata : hw_data_reg;
  wire wr_ok = wr_any & ~full;
  wire ovf_set = wr_any & full;

  // Read arbitration, host first
  wire host_pop = a_sel & ~hwrite & (a_addr == `RXPF_A_DATA) & ~empty;
  wire crc_pop = (c_state_reg == C_FETCH) & ~empty & ~host_pop;
  wire pop = host_pop | crc_pop;

  // Alert levels
  wire [6:0] room = `RXPF_DEPTH - fill;
  wire nf_now = (room <= {1'b0, thr_reg});
  wire ne_now = (fill <= {1'b0, thr_reg});
  wire hw_pend_next = (hw_pend_reg & rx_wr) | w_data;

  // CRC step on one bit
  wire c_bit = cfg_reg[`RXPF_F_MSB] ? c_sh_reg[7] : c_sh_reg[0];
  wire fb_m = crc_reg[15] ^ c_bit;
  wire fb_l = crc_reg[0] ^ c_bit;
  wire [15:0] crc_m = {crc_reg[14:0], 1'b0} ^ (fb_m ? `RXPF_POLY_M : 16'h0);
  wire [15:0] crc_l = {1'b0, crc_reg[15:1]} ^ (fb_l ? `RXPF_POLY_L : 16'h0);
  wire [7:0] sh_m = {c_sh_reg[6:0], 1'b0};
  wire [7:0] sh_l = {1'b0, c_sh_reg[7:1]};
  reg [15:0] seed;

  always @* begin
    case (cfg_reg[1:0])
      2'd0: seed = `RXPF_SEED0;
      2'd1: seed = `RXPF_SEED1;
      2'd2: seed = `RXPF_SEED2;
      2'd3: seed = `RXPF_SEED3;
      default: seed = `RXPF_SEED0;
    endcase
  end

  // Read data mux for the address phase
  reg [31:0] rmux;
  always @* begin
    rmux = 32'h0;
    case (a_addr)
      `RXPF_A_DATA: rmux[7:0] = empty ? 8'h00 : mem[rp_reg[5:0]];
      `RXPF_A_FILL: rmux[6:0] = fill;
      `RXPF_A_THR: rmux[5:0] = thr_reg;
      `RXPF_A_STAT: rmux[3:0] = {rx_active, crc_rdy_reg, nf_reg, ne_reg};
      `RXPF_A_ERR: rmux[4:0] = {ovf_reg, err_reg};
      `RXPF_A_IEN: rmux[1:0] = ien_reg;
      `RXPF_A_IRQ: rmux[1:0] = irqf_reg;
      `RXPF_A_MIRQ: rmux[`RXPF_F_CRCDONE] = crc_done_reg;
      `RXPF_A_CFG: rmux[2:0] = cfg_reg;
      `RXPF_A_CRCH: rmux[7:0] = crc_reg[15:8];
      `RXPF_A_CRCL: rmux[7:0] = crc_reg[7:0];
      `RXPF_A_RXCFG: rmux[1:0] = {rx_active, multi_reg};
      `RXPF_A_WLO: rmux[5:0] = wlo_reg;
      `RXPF_A_WHI: rmux[5:0] = whi_reg;
      default: rmux = 32'h0;
    endcase
  end

  // Buffer array, no reset
  always @(posedge clock) begin
    if (wr_ok) begin
      mem[wp_reg[5:0]] <= wdata;
    end
  end

  // Pointers and overflow
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wp_reg <= 7'd0;
      rp_reg <= 7'd0;
      ovf_reg <= 1'b0;
    end else begin
      if (flush) begin
        wp_reg <= 7'd0;
        rp_reg <= 7'd0;
      end else begin
        if (wr_ok) begin
          wp_reg <= wp_reg + 7'd1;
        end
        if (pop) begin
          rp_reg <= rp_reg + 7'd1;
        end
      end
      if (ovf_set) begin
        ovf_reg <= 1'b1;
      end else if (flush) begin
        ovf_reg <= 1'b0;
      end
    end
  end

  // Bus slave
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      d_wr_reg <= 1'b0;
      d_addr_reg <= 8'h00;
      hw_pend_reg <= 1'b0;
      hw_data_reg <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (hready) begin
        d_wr_reg <= a_sel & hwrite;
        d_addr_reg <= a_addr;
      end
      if (a_sel & ~hwrite) begin
        hrdata <= rmux;
      end
      if (w_data) begin
        hw_data_reg <= wd8;
      end
      hw_pend_reg <= hw_pend_next;
      hreadyout <= ~hw_pend_next;
    end
  end

  // Configuration and interrupt registers
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      thr_reg <= `RXPF_THR_RST;
      ien_reg <= 2'b00;
      cfg_reg <= `RXPF_CFG_RST;
      wlo_reg <= `RXPF_WIN_RST;
      whi_reg <= `RXPF_WIN_RST;
      ne_reg <= 1'b1;
      nf_reg <= 1'b0;
      irqf_reg <= 2'b00;
      irq <= 1'b0;
    end else begin
      if (d_we) begin
        case (d_addr_reg)
          `RXPF_A_THR: thr_reg <= wd8[5:0];
          `RXPF_A_IEN: ien_reg <= wd8[1:0];
          `RXPF_A_CFG: cfg_reg <= wd8[2:0];
          `RXPF_A_WLO: wlo_reg <= wd8[5:0];
          `RXPF_A_WHI: whi_reg <= wd8[5:0];
          default: ;
        endcase
      end
      ne_reg <= ne_now;
      nf_reg <= nf_now;
      // Request flags: rising edge sets, write one clears, set wins
      irqf_reg[`RXPF_F_NE] <= (ne_now & ~ne_reg)
        | (irqf_reg[`RXPF_F_NE] & ~(w_irq & wd8[`RXPF_F_NE]));
      irqf_reg[`RXPF_F_NF] <= (nf_now & ~nf_reg)
        | (irqf_reg[`RXPF_F_NF] & ~(w_irq & wd8[`RXPF_F_NF]));
      irq <= |(irqf_reg & ien_reg);
    end
  end

  // Receive control
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      multi_reg <= 1'b0;
      rx_active <= 1'b0;
      rx_first_reg <= 1'b1;
      rx_keep_reg <= 1'b0;
      err_reg <= 4'h0;
    end else begin
      if (rx_take & rx_first_reg) begin
        rx_first_reg <= 1'b0;
        rx_keep_reg <= in_win;
      end
      if (rx_active & rx_end) begin
        rx_first_reg <= 1'b1;
        rx_keep_reg <= 1'b0;
        if (rx_swr) begin
          err_reg <= rx_err;
          if (!multi_reg) begin
            rx_active <= 1'b0;
          end
        end
      end
      if (w_rxcfg) begin
        multi_reg <= wd8[`RXPF_F_MULTI];
        rx_active <= wd8[`RXPF_F_RXON];
        if (!rx_active) begin
          rx_first_reg <= 1'b1;
          rx_keep_reg <= 1'b0;
        end
      end
    end
  end

  // CRC coprocessor
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      c_state_reg <= C_IDLE;
      crc_reg <= `RXPF_SEED0;
      c_sh_reg <= 8'h00;
      c_cnt_reg <= 3'd0;
      crc_rdy_reg <= 1'b0;
      crc_done_reg <= 1'b0;
    end else begin
      case (c_state_reg)
        C_IDLE: begin
          if (w_crcgo) begin
            crc_reg <= seed;
            crc_rdy_reg <= 1'b0;
            c_state_reg <= C_FETCH;
          end
        end
        C_FETCH: begin
          if (empty) begin
            crc_rdy_reg <= 1'b1;
            c_state_reg <= C_IDLE;
          end else if (crc_pop) begin
            c_sh_reg <= mem[rp_reg[5:0]];
            c_cnt_reg <= 3'd0;
            c_state_reg <= C_SHIFT;
          end
        end
        C_SHIFT: begin
          if (cfg_reg[`RXPF_F_MSB]) begin
            crc_reg <= crc_m;
            c_sh_reg <= sh_m;
          end else begin
            crc_reg <= crc_l;
            c_sh_reg <= sh_l;
          end
          c_cnt_reg <= c_cnt_reg + 3'd1;
          if (c_cnt_reg == `RXPF_BITS) begin
            c_state_reg <= C_FETCH;
          end
        end
        default: c_state_reg <= C_IDLE;
      endcase
      if ((c_state_reg == C_FETCH) & empty) begin
        crc_done_reg <= 1'b1;
      end else if (w_mirq & wd8[`RXPF_F_CRCDONE]) begin
        crc_done_reg <= 1'b0;
      end
    end
  end

endmodule // rxpf_top

// >>> logic/rxpf_regs.vh
// Purpose: Register map, field positions and constants of the rx buffer
// Assumes: AHB-Lite byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef RXPF_REGS_VH
`define RXPF_REGS_VH

// Register byte offsets
`define RXPF_A_DATA 8'h00
`define RXPF_A_FILL 8'h04
`define RXPF_A_THR 8'h08
`define RXPF_A_STAT 8'h0c
`define RXPF_A_ERR 8'h10
`define RXPF_A_IEN 8'h14
`define RXPF_A_IRQ 8'h18
`define RXPF_A_MIRQ 8'h1c
`define RXPF_A_CFG 8'h20
`define RXPF_A_CRCGO 8'h24
`define RXPF_A_CRCH 8'h28
`define RXPF_A_CRCL 8'h2c
`define RXPF_A_RXCFG 8'h30
`define RXPF_A_WLO 8'h34
`define RXPF_A_WHI 8'h38

// Field positions
`define RXPF_F_FLUSH 7
`define RXPF_F_NE 0
`define RXPF_F_NF 1
`define RXPF_F_CRCRDY 2
`define RXPF_F_RXACT 3
`define RXPF_F_OVF 4
`define RXPF_F_CRCDONE 2
`define RXPF_F_MSB 2
`define RXPF_F_MULTI 0
`define RXPF_F_RXON 1
`define RXPF_F_CRCGO 0

// Reset values
`define RXPF_THR_RST 6'h08
`define RXPF_CFG_RST 3'h0
`define RXPF_WIN_RST 6'h00

// Buffer size and CRC constants
`define RXPF_DEPTH 7'd64
`define RXPF_BITS 3'd7
`define RXPF_SEED0 16'h0000
`define RXPF_SEED1 16'h6363
`define RXPF_SEED2 16'ha671
`define RXPF_SEED3 16'hffff
`define RXPF_POLY_M 16'h1021
`define RXPF_POLY_L 16'h8408
`define RXPF_MAX_OPEN 9'h100

`endif

// >>> verif/rxpf_top_assertions.sv
// Purpose: Port assertions for the rx buffer block
// Assumes: hready is tied to hreadyout
// Notes: Bound into every rxpf_top
`timescale 1ns/1ps
module rxpf_top_assertions (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // Receiver and interrupt
  input wire rx_active,
  input wire irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  wire take = hsel && htrans[1] && hready;
  wire rd = take && !hwrite;
  wire [7:0] a = haddr[7:0];
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  chk_wr_stall: assert property (take && hwrite && a == 8'h00
    |-> ##[1:4] (hreadyout ##1 !hreadyout)) else $error("no write stall");
  chk_ready_back: assert property (!hreadyout |-> ##[1:4] hreadyout)
    else $error("bus stuck");
  chk_unmapped_zero: assert property (rd && a >= 8'h3c |=> hrdata == 0)
    else $error("unmapped read not zero");
  chk_fill_range: assert property (rd && a == 8'h04
    |=> hrdata[31:7] == 25'h0 && hrdata[6:0] <= 7'd64)
    else $error("fill out of range");
  chk_crc_byte: assert property (rd && (a == 8'h28 || a == 8'h2c)
    |=> hrdata[31:8] == 24'h0) else $error("crc byte too wide");
  chk_stat_active: assert property (rd && a == 8'h0c
    |=> hrdata[3] == $past(rx_active)) else $error("status active bit");
  chk_rst_quiet: assert property ($rose(resetn)
    |-> !irq && !rx_active && hreadyout) else $error("bad reset outputs");
  chk_rdata_hold: assert property (!rd |=> $stable(hrdata))
    else $error("hrdata moved");
  cover property (take && hwrite && a == 8'h00);
  cover property ($rose(irq));
  cover property ($fell(rx_active));
endmodule // rxpf_top_assertions

bind rxpf_top rxpf_top_assertions i_rxpf_top_assertions (.clock(clock),
  .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .rx_active(rx_active), .irq(irq));

// >>> verif/rxpf_rx_src.sv
// Purpose: Receive decoder model feeding packets
// Assumes: Driven just after rising edges
// Notes: Idle data shows the inverse of the last value
`timescale 1ns/1ps
module rxpf_rx_src (
  // Clock
  input wire clock,
  // Decoder outputs
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_end,
  output logic [3:0] rx_err
);
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_end = 1'b0;
    rx_err = 4'h0;
  end
  // Length byte, payload 8'h40+i, then end with flags
  task automatic send(input [7:0] len, input [7:0] n, input [3:0] err);
    integer i;
    for (i = 0; i < n; i++) begin
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_data <= (i == 0) ? len : 8'h40 + i[7:0];
    end
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    rx_end <= 1'b1;
    rx_err <= err;
    @(posedge clock);
    rx_end <= 1'b0;
    rx_err <= ~err;
  endtask
endmodule // rxpf_rx_src

// >>> verif/tb_rxpf_top.sv
// Purpose: Register-level tests of the rx buffer block
// Assumes: Single AHB-Lite master, one slave
// Notes: Packets come from the decoder model
`timescale 1ns/1ps
module tb_rxpf_top;
  logic clock, resetn, hsel, hwrite;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, q;
  logic [15:0] c;
  logic [15:0] seeds [0:3] = '{16'h0000, 16'h6363, 16'ha671, 16'hffff};
  wire [31:0] hrdata;
  wire hreadyout, hresp, rx_valid, rx_end, rx_active, irq;
  wire [7:0] rx_data;
  wire [3:0] rx_err;
  integer err_total = 0, n_tests = 0, cyc = 0, i, s;

  rxpf_top i_rxpf_top (.clock(clock), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_end(rx_end), .rx_err(rx_err),
    .rx_active(rx_active), .irq(irq));
  rxpf_rx_src i_rxpf_rx_src (.clock(clock), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_end(rx_end), .rx_err(rx_err));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task give_verdict;
    $display("Checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      err_total++;
      give_verdict;
    end
  end

  task chk(input string nm, input [31:0] e, input [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One single transfer; called just after a rising edge
  task ahb(input [7:0] a, input w, input [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    hsel <= 1'b1;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    q = hrdata;
  endtask

  task rc(input string nm, input [7:0] a, input [31:0] m, input [31:0] e);
    ahb(a, 1'b0, 32'h0);
    chk(nm, e, q & m);
  endtask

  // Reads one stored packet back
  task pk(input [7:0] len, input [7:0] n, input [3:0] err);
    for (i = 0; i <= n; i++)
      rc("rxbyte", 8'h00, 32'hff, i == 0 ? len : i == n ? err : 8'h40 + i);
  endtask

  function automatic [15:0] crc16(input [15:0] c, input m, input [7:0] b);
    integer k;
    for (k = 0; k < 8; k++)
      if (m) c = c[15] ^ b[7-k] ? (c << 1) ^ 16'h1021 : c << 1;
      else c = c[0] ^ b[k] ? (c >> 1) ^ 16'h8408 : c >> 1;
    return c;
  endfunction

  initial begin
    resetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rc("thr", 8'h08, 32'hff, 32'h8);
    rc("stat", 8'h0c, 32'h3, 32'h1);
    rc("unmapped", 8'h3c, 32'hffffffff, 32'h0);
    for (i = 0; i < 3; i++) ahb(8'h00, 1'b1, 8'ha0 + i);
    rc("fill", 8'h04, 32'hff, 32'h3);
    for (s = 0; s < 3; s++) rc("pop", 8'h00, 32'hff, 8'ha0 + s);
    ahb(8'h14, 1'b1, 32'h2);
    for (s = 0; s < 65; s++) begin
      if (s == 55 || s == 56) begin
        repeat (2) @(posedge clock);
        rc("nf", 8'h0c, 32'h2, s == 56 ? 2 : 0);
      end
      ahb(8'h00, 1'b1, s);
    end
    rc("fill", 8'h04, 32'hff, 32'd64);
    rc("ovf", 8'h10, 32'h10, 32'h10);
    chk("irq", 32'h1, {31'h0, irq});
    rc("nfreq", 8'h18, 32'h2, 32'h2);
    ahb(8'h18, 1'b1, 32'h3);
    rc("pop", 8'h00, 32'hff, 32'h0);
    rc("ovf", 8'h10, 32'h10, 32'h10);
    chk("irq", 32'h0, {31'h0, irq});
    ahb(8'h04, 1'b1, 32'h80);
    rc("fill", 8'h04, 32'hff, 32'h0);
    rc("ovf", 8'h10, 32'h10, 32'h0);
    rc("empty", 8'h00, 32'hff, 32'h0);
    rc("nereq", 8'h18, 32'h1, 32'h1);
    ahb(8'h14, 1'b1, 32'h1);
    repeat (2) @(posedge clock);
    chk("irq", 32'h1, {31'h0, irq});
    ahb(8'h34, 1'b1, 32'h4);
    ahb(8'h38, 1'b1, 32'h5);
    ahb(8'h30, 1'b1, 32'h3);
    i_rxpf_rx_src.send(8'd18, 8'd18, 4'h5);
    i_rxpf_rx_src.send(8'd20, 8'd20, 4'h0);
    i_rxpf_rx_src.send(8'd15, 8'd2, 4'h0);
    i_rxpf_rx_src.send(8'd16, 8'd3, 4'h2);
    rc("fill", 8'h04, 32'hff, 32'd23);
    rc("errflags", 8'h10, 32'hf, 32'h2);
    chk("active", 32'h1, {31'h0, rx_active});
    pk(8'd18, 8'd18, 4'h5);
    pk(8'd16, 8'd3, 4'h2);
    ahb(8'h38, 1'b1, 32'h0);
    ahb(8'h30, 1'b1, 32'h2);
    i_rxpf_rx_src.send(8'hff, 8'd2, 4'h0);
    pk(8'hff, 8'd2, 4'h0);
    chk("active", 32'h0, {31'h0, rx_active});
    for (s = 0; s < 4; s++) begin
      ahb(8'h20, 1'b1, {29'h0, s[0], s[1:0]});
      ahb(8'h00, 1'b1, 32'h12);
      ahb(8'h00, 1'b1, 32'h34);
      ahb(8'h24, 1'b1, 32'h1);
      c = crc16(crc16(seeds[s], s[0], 8'h12), s[0], 8'h34);
      q = 32'h0;
      for (i = 0; i < 40 && q[2] !== 1'b1; i++) ahb(8'h1c, 1'b0, 0);
      chk("crcdone", 32'h4, q & 32'h4);
      rc("crch", 8'h28, 32'hffffffff, c[15:8]);
      rc("crcl", 8'h2c, 32'hffffffff, c[7:0]);
      ahb(8'h1c, 1'b1, 32'h4);
    end
    give_verdict;
  end
endmodule // tb_rxpf_top
